// ===== hdl/pbm_basic_mode_control.sv
// Purpose: basic mode control register of a 10/100 transceiver, APB slave
// Assumes: MII transmit and phy receive signals are produced on clk
// Notes: negotiation engine and analog path sit outside this block
// Functional notes
// - writing one to bit 15 starts a reset; reads one until done, then clears
// - soft reset reloads configuration from the synchronised strap pins like a hardware reset
// - loopback bit 14 routes transmit data back onto the receive path
// - after loopback is enabled, receive valid is withheld for about 500 us
// - bit 13 picks 100 Mb/s when one, 10 Mb/s when zero; strap initial
// - negotiation enable bit 12 starts from a strap and stays writable
// - with fiber mode strapped, negotiation enable resets to zero
// - negotiation on ignores speed and duplex bits; off, they decide
// - power down bit 11 stops the transceiver; registers keep working
// - power down is bit OR low pin; low pin also sets the bit
// - isolate bit 10 cuts the port from the MII, management stays
// - writing one to restart bit 9 restarts negotiation from its start
// - restart write of one is ignored while negotiation enable is zero
// - restart bit reads one until negotiation is initiated, then clears
// - writing zero to a set restart bit does not affect negotiation
// - duplex bit 8 picks full when one, half when zero; strap initial
// - collision test bit 7 raises COL within 512 bit times of TX_EN
// - in collision test COL drops within 4 bit times of TX_EN falling; here one clock later, 10 bit times at 100 Mb/s
// - bits 6 to 0 ignore writes and read as zero
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module pbm_basic_mode_control
   import pbm_pkg::*;
#(
   parameter int DEAD_CYCLES = DEAD_TIME_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // straps and power down pin
   input wire logic strap_speed_100,
   input wire logic strap_full_duplex,
   input wire logic strap_an_enable,
   input wire logic fiber_mode_enable,
   input wire logic power_down_request_pin_b,
   // negotiation engine
   input wire logic an_initiated,
   input wire logic an_speed_100,
   input wire logic an_full_duplex,
   output logic an_enable,
   output logic an_restart,
   // port control
   output logic speed_100,
   output logic full_duplex,
   output logic power_down,
   output logic isolate,
   output logic soft_reset_active,
   // mii transmit from mac
   input wire logic [3:0] mii_txd,
   input wire logic mii_tx_en,
   // receive path and collision from the line side
   input wire logic [3:0] phy_rxd,
   input wire logic phy_rx_dv,
   input wire logic phy_col,
   // mii receive towards mac
   output logic [3:0] mii_rxd,
   output logic mii_rx_dv,
   output logic mii_col
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed
   {
      logic rst_busy;
      logic [4:0] rst_cnt;
      logic loop;
      logic speed;
      logic an_en;
      logic pdown;
      logic iso;
      logic restart;
      logic duplex;
      logic coltest;
      logic [15:0] dead_cnt;
      logic [3:0] rxd;
      logic rx_dv;
      logic col;
      logic speed_eff;
      logic duplex_eff;
      logic pdown_eff;
      logic [15:0] rdata;
   } pbm_state_t;

   pbm_state_t q;
   pbm_state_t d;
   logic [SYNC_W-1:0] pins_s;
   logic wr_en;
   logic rd_setup;
   logic addr_hit;
   logic restart_set;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // reload strap bits and clear the rest of the control bits
   function automatic pbm_state_t load_straps(input pbm_state_t s,
                                              input logic [SYNC_W-1:0] p);
      pbm_state_t r;
      r = s;
      r.loop = 1'b0;
      r.pdown = 1'b0;
      r.iso = 1'b0;
      r.restart = 1'b0;
      r.coltest = 1'b0;
      r.speed = p[SYNC_SPEED];
      r.duplex = p[SYNC_DUPLEX];
      r.an_en = p[SYNC_AN] & ~p[SYNC_FIBER];
      return r;
   endfunction : load_straps

   // register image as software sees it
   function automatic logic [15:0] reg_image(input pbm_state_t s);
      logic [15:0] v;
      v = {s.rst_busy, s.loop, s.speed, s.an_en, s.pdown, s.iso, s.restart,
           s.duplex, s.coltest, RESERVED_LOW_VALUE};
      return v;
   endfunction : reg_image

   // ------------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------------
   pbm_sync3 #(
      .W(SYNC_W),
      .RST_VAL(SYNC_RESET_VALUE)
   ) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pin_in({power_down_request_pin_b, fiber_mode_enable, strap_an_enable,
               strap_full_duplex, strap_speed_100}),
      .level_out(pins_s)
   );

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   // zero wait states; unmapped words answer with an error
   assign addr_hit = (paddr[11:2] == BASIC_MODE_CONTROL_ADDR[11:2]);
   assign wr_en = psel & penable & pwrite & addr_hit;
   assign rd_setup = psel & ~penable;
   assign restart_set = wr_en & pstrb[1] & ~q.rst_busy & pwdata[AN_RESTART_BIT]
                        & pwdata[AN_ENABLE_BIT];

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb
   begin
      d = q;
      // reset sequencing, hardware or soft
      if (q.rst_busy)
      begin
         d.rst_cnt = q.rst_cnt - 5'h01;
         if (q.rst_cnt == 5'h00)
         begin
            d = load_straps(q, pins_s);
            d.rst_busy = 1'b0;
            d.rst_cnt = 5'h00;
         end
      end
      else if (wr_en)
      begin
         // high byte lane holds bits 15..8
         if (pstrb[1])
         begin
            if (pwdata[SOFT_RESET_BIT])
            begin
               d.rst_busy = 1'b1;
               d.rst_cnt = SOFT_RESET_LOAD;
            end
            d.loop = pwdata[LOOPBACK_BIT];
            d.speed = pwdata[SPEED_BIT];
            d.an_en = pwdata[AN_ENABLE_BIT];
            d.pdown = pwdata[POWER_DOWN_BIT];
            d.iso = pwdata[ISOLATE_BIT];
            d.duplex = pwdata[DUPLEX_BIT];
         end
         // low byte lane holds bit 7; bits 6..0 ignored
         if (pstrb[0])
         begin
            d.coltest = pwdata[COL_TEST_BIT];
         end
      end
      // restart: zero writes ignored, set wins over completion
      if (restart_set)
      begin
         d.restart = 1'b1;
      end
      else if (q.restart && an_initiated)
      begin
         d.restart = 1'b0;
      end
      // low pin forces the power down bit
      if (!pins_s[SYNC_PD_B] && !q.rst_busy)
      begin
         d.pdown = 1'b1;
      end
      // dead time after loopback is switched on
      if (d.loop && !q.loop)
      begin
         d.dead_cnt = 16'(DEAD_CYCLES);
      end
      else if (q.dead_cnt != 16'h0000)
      begin
         d.dead_cnt = q.dead_cnt - 16'h0001;
      end
      // receive path and collision
      if (q.iso || q.pdown_eff)
      begin
         d.rxd = 4'h0;
         d.rx_dv = 1'b0;
         d.col = 1'b0;
      end
      else
      begin
         if (q.loop)
         begin
            d.rxd = mii_txd;
            d.rx_dv = mii_tx_en & (q.dead_cnt == 16'h0000);
         end
         else
         begin
            d.rxd = phy_rxd;
            d.rx_dv = phy_rx_dv;
         end
         d.col = q.coltest ? mii_tx_en : phy_col;
      end
      // effective speed, duplex and power
      d.speed_eff = q.an_en ? an_speed_100 : q.speed;
      d.duplex_eff = q.an_en ? an_full_duplex : q.duplex;
      d.pdown_eff = q.pdown | ~pins_s[SYNC_PD_B];
      // read data captured in the setup cycle
      if (rd_setup)
      begin
         d.rdata = addr_hit ? reg_image(q) : 16'h0000;
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   // hardware reset enters the same sequence a soft reset uses
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q <= '0;
         q.rst_busy <= 1'b1;
         q.rst_cnt <= SOFT_RESET_LOAD;
      end
      else
      begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign prdata = {PRDATA_ZERO[31:16], q.rdata};
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_hit;
   assign an_enable = q.an_en;
   assign an_restart = q.restart;
   assign speed_100 = q.speed_eff;
   assign full_duplex = q.duplex_eff;
   assign power_down = q.pdown_eff;
   assign isolate = q.iso;
   assign soft_reset_active = q.rst_busy;
   assign mii_rxd = q.rxd;
   assign mii_rx_dv = q.rx_dv;
   assign mii_col = q.col;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   reset_self_clear_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      $rose(q.rst_busy) |-> q.rst_busy [*8] ##[1:9] !q.rst_busy)
      else $error("soft reset bit did not self clear in time");

   restart_ignored_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      (wr_en && pstrb[1] && !pwdata[AN_ENABLE_BIT] && !q.restart) |=> !q.restart)
      else $error("restart accepted while negotiation disabled");

   restart_hold_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      (q.restart && !an_initiated && !q.rst_busy) |=> q.restart)
      else $error("restart bit cleared before negotiation started");

   pin_sets_pdown_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      (!pins_s[SYNC_PD_B] && !q.rst_busy) |=> (q.pdown && power_down))
      else $error("power down pin did not set the bit");

   col_follow_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      (q.coltest && !q.iso && !q.pdown_eff) |=> (mii_col == $past(mii_tx_en)))
      else $error("collision test output does not follow transmit enable");

   reserved_zero_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      prdata[6:0] == RESERVED_LOW_VALUE)
      else $error("reserved bits read nonzero");

   loop_dead_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      ($rose(q.loop) && DEAD_CYCLES > 8) |=> !mii_rx_dv [*8])
      else $error("receive valid during loopback dead time");

   forced_speed_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      !q.an_en |=> (speed_100 == $past(q.speed) && full_duplex == $past(q.duplex)))
      else $error("forced speed or duplex not applied");

   isolate_quiet_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      q.iso |=> (!mii_rx_dv && !mii_col && mii_rxd == 4'h0))
      else $error("mii outputs active while isolated");

   loop_echo_a: assert property (
      @(posedge clk) disable iff (!rst_b)
      (q.loop && !q.iso && !q.pdown_eff) |=> (mii_rxd == $past(mii_txd)))
      else $error("loopback data not routed to receive path");

endmodule : pbm_basic_mode_control

// ===== hdl/pbm_pkg.sv
// Purpose: shared constants for the basic mode control register block
// Assumes: 10 MHz clock, APB register access, one 16-bit register at offset 0x00
// Notes: bit positions, reset counts and timing figures are defined once here
package pbm_pkg;

   // ------------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int DEAD_TIME_US = 500;
   // loopback dead time in clock cycles (longest time, rounds down)
   localparam int DEAD_TIME_CYCLES = (DEAD_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int SOFT_RESET_CYCLES = 16;
   localparam logic [4:0] SOFT_RESET_LOAD = 5'(SOFT_RESET_CYCLES - 1);
   localparam int COL_ASSERT_BIT_TIMES = 512;
   localparam int COL_DEASSERT_BIT_TIMES = 4;
   localparam int BIT_TIME_100_NS = 10;
   // longest collision delays in cycles, never below one cycle
   localparam int COL_ASSERT_CYCLES =
      (COL_ASSERT_BIT_TIMES * BIT_TIME_100_NS / CLK_PERIOD_NS < 1) ? 1 :
      COL_ASSERT_BIT_TIMES * BIT_TIME_100_NS / CLK_PERIOD_NS;
   localparam int COL_DEASSERT_CYCLES =
      (COL_DEASSERT_BIT_TIMES * BIT_TIME_100_NS / CLK_PERIOD_NS < 1) ? 1 :
      COL_DEASSERT_BIT_TIMES * BIT_TIME_100_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [11:0] BASIC_MODE_CONTROL_ADDR = 12'h000;
   localparam int SOFT_RESET_BIT = 15;
   localparam int LOOPBACK_BIT = 14;
   localparam int SPEED_BIT = 13;
   localparam int AN_ENABLE_BIT = 12;
   localparam int POWER_DOWN_BIT = 11;
   localparam int ISOLATE_BIT = 10;
   localparam int AN_RESTART_BIT = 9;
   localparam int DUPLEX_BIT = 8;
   localparam int COL_TEST_BIT = 7;
   localparam logic [6:0] RESERVED_LOW_VALUE = 7'h00;
   localparam logic [31:0] PRDATA_ZERO = 32'h0000_0000;

   // ------------------------------------------------------------------
   // synchroniser lanes: straps and power down pin
   // ------------------------------------------------------------------
   localparam int SYNC_W = 5;
   localparam int SYNC_SPEED = 0;
   localparam int SYNC_DUPLEX = 1;
   localparam int SYNC_AN = 2;
   localparam int SYNC_FIBER = 3;
   localparam int SYNC_PD_B = 4;
   // pin reset levels: straps low, power down pin idle high
   localparam logic [4:0] SYNC_RESET_VALUE = 5'h10;

endpackage : pbm_pkg

// ===== hdl/pbm_sync3.sv
// Purpose: three-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: output changes only once the second and third flops agree
`timescale 1ns/1ps
module pbm_sync3
   import pbm_pkg::*;
#(
   parameter int W = SYNC_W,
   parameter logic [SYNC_W-1:0] RST_VAL = SYNC_RESET_VALUE
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pins in, filtered level out
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);

   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } pbm_sync_t;

   pbm_sync_t q;
   pbm_sync_t d;

   // shift chain; first flop feeds only the second
   always_comb
   begin
      d = q;
      d.s1 = pin_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < W; i++)
      begin
         if (q.s2[i] == q.s3[i])
         begin
            d.lvl[i] = q.s3[i];
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q <= {4{RST_VAL[W-1:0]}};
      end
      else
      begin
         q <= d;
      end
   end

   assign level_out = q.lvl;

endmodule : pbm_sync3

// ===== sim/pbm_mac_model.sv
// Purpose: mac transmit source and negotiation engine stand-in
// Assumes: runs on the block clock
// Notes: ack_wait sets how slowly the engine starts a negotiation
`timescale 1ns/1ps
module pbm_mac_model
   import pbm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // bench control
   input wire logic tx_on,
   input wire logic [3:0] ack_wait,
   // towards the block
   input wire logic an_restart,
   output logic [3:0] mii_txd,
   output logic mii_tx_en,
   output logic an_initiated
);
   typedef struct packed
   {
      logic [3:0] txd;
      logic tx_en;
      logic [3:0] cnt;
      logic init;
   } pbm_mac_st_t;
   pbm_mac_st_t st_q;
   pbm_mac_st_t st_d;

   // frame data counts up; idle data flips so nothing stale looks valid
   always_comb
   begin
      st_d = st_q;
      st_d.tx_en = tx_on;
      st_d.txd = tx_on ? st_q.txd + 4'h1 : ~st_q.txd;
      st_d.init = 1'b0;
      st_d.cnt = an_restart ? st_q.cnt + 4'h1 : 4'h0;
      if (an_restart && st_q.cnt == ack_wait)
      begin
         st_d.init = 1'b1;
         st_d.cnt = 4'h0;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign mii_txd = st_q.txd;
   assign mii_tx_en = st_q.tx_en;
   assign an_initiated = st_q.init;
endmodule : pbm_mac_model

// ===== sim/phy_basic_mode_control_bench.sv
// Purpose: self-checking bench for the basic mode control register
// Assumes: apb master in this bench, mac model on the mii side
// Notes: loopback dead time shortened to 20 cycles
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module phy_basic_mode_control_bench
   import pbm_pkg::*;
;
   typedef struct packed
   {
      logic [15:0] w;
      logic [15:0] r;
      logic spd;
      logic dup;
      logic dv;
   } pbm_row_t;
   localparam pbm_row_t ROWS [0:5] = '{
      '{16'h217F, 16'h2100, 1'b1, 1'b1, 1'b1}, '{16'h3100, 16'h3100, 1'b0, 1'b1, 1'b1},
      '{16'h0200, 16'h0000, 1'b0, 1'b0, 1'b1}, '{16'h0400, 16'h0400, 1'b0, 1'b0, 1'b0},
      '{16'h0800, 16'h0800, 1'b0, 1'b0, 1'b0}, '{16'h0000, 16'h0000, 1'b0, 1'b0, 1'b1}};
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
   logic [3:0] pstrb = 4'hF, mii_txd, mii_rxd, ack_wait = 4'h8, t;
   logic pready, pslverr, rerr, s_spd = 1'b1, s_dup = 1'b0, s_an = 1'b1, s_fib = 1'b0;
   logic pd_b = 1'b1, a_spd = 1'b0, an_init, an_enable, an_restart, speed_100, full_duplex;
   logic power_down, isolate, sr_act, mii_tx_en, mii_rx_dv, mii_col, tx_on = 1'b0;
   int err_total = 0, n_tests = 0, i;

   always #50 clk = ~clk;

   pbm_basic_mode_control #(.DEAD_CYCLES(20)) dut (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_speed_100(s_spd),
      .strap_full_duplex(s_dup), .strap_an_enable(s_an), .fiber_mode_enable(s_fib),
      .power_down_request_pin_b(pd_b), .an_initiated(an_init), .an_speed_100(a_spd),
      .an_full_duplex(1'b1), .an_enable(an_enable), .an_restart(an_restart),
      .speed_100(speed_100), .full_duplex(full_duplex), .power_down(power_down),
      .isolate(isolate), .soft_reset_active(sr_act), .mii_txd(mii_txd),
      .mii_tx_en(mii_tx_en), .phy_rxd(4'hA), .phy_rx_dv(1'b1), .phy_col(1'b0),
      .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_col(mii_col));

   pbm_mac_model mac (.clk(clk), .rst_b(rst_b), .tx_on(tx_on), .ack_wait(ack_wait),
      .an_restart(an_restart), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en),
      .an_initiated(an_init));

   // ---------------------------------------------------------------
   // bus and wait helpers
   // ---------------------------------------------------------------
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         `CHK(pready, 1'b1)
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // bounded wait for a flag to reach a level
   task automatic wait_for(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      if (s !== v)
         `CHK(s, v)
   endtask : wait_for

   task automatic final_report;
      $display("tests %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      wait_for(sr_act, 1'b0);
      apb(0, 12'h000, 16'h0000);
      `CHK(rdata, 32'h0000_3000)
      // table of plain writes and their effects
      for (i = 0; i < 6; i++)
      begin
         apb(1, 12'h000, ROWS[i].w);
         apb(0, 12'h000, 16'h0000);
         `CHK(rdata[15:0], ROWS[i].r)
         `CHK({speed_100, full_duplex}, {ROWS[i].spd, ROWS[i].dup})
         `CHK(mii_rx_dv, ROWS[i].dv)
         `CHK({isolate, power_down}, {ROWS[i].w[10], ROWS[i].w[11]})
      end
      $display("table done");
      // unmapped address
      apb(1, 12'h004, 16'hFFFF);
      `CHK(rerr, 1'b1)
      apb(0, 12'h004, 16'h0000);
      `CHK(rdata, 32'h0000_0000)
      // restart with a slow engine; a zero write in between leaves it set
      apb(1, 12'h000, 16'h1200);
      apb(0, 12'h000, 16'h0000);
      `CHK(rdata[15:0], 16'h1200)
      apb(1, 12'h000, 16'h1000);
      @(posedge clk);
      `CHK(an_restart, 1'b1)
      wait_for(an_restart, 1'b0);
      apb(0, 12'h000, 16'h0000);
      `CHK(rdata[15:0], 16'h1000)
      // negotiated speed wins over bit 13 while enabled
      a_spd <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK({an_enable, speed_100}, 2'b11)
      $display("restart done");
      // loopback with dead time, then echoed data
      apb(1, 12'h000, 16'h4000);
      tx_on <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(mii_rx_dv, 1'b0)
      repeat (30) @(posedge clk);
      @(negedge clk) t = mii_txd;
      @(negedge clk) `CHK({mii_rx_dv, mii_rxd}, {1'b1, t})
      @(posedge clk);
      tx_on <= 1'b0;
      // collision test follows transmit enable both ways
      apb(1, 12'h000, 16'h0080);
      `CHK(mii_col, 1'b0)
      tx_on <= 1'b1;
      wait_for(mii_col, 1'b1);
      tx_on <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(mii_col, 1'b0)
      $display("mii done");
      // power down pin sets the bit, which stays after release
      apb(1, 12'h000, 16'h0000);
      pd_b <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK(power_down, 1'b1)
      pd_b <= 1'b1;
      repeat (8) @(posedge clk);
      apb(0, 12'h000, 16'h0000);
      `CHK(rdata[15:0], 16'h0800)
      // soft reset restraps with fiber mode on
      s_fib <= 1'b1;
      s_dup <= 1'b1;
      repeat (6) @(posedge clk);
      apb(1, 12'h000, 16'h8000);
      apb(0, 12'h000, 16'h0000);
      `CHK(rdata[15], 1'b1)
      wait_for(sr_act, 1'b0);
      apb(0, 12'h000, 16'h0000);
      `CHK(rdata[15:0], 16'h2100)
      $display("reset done");
      // hardware reset in mid run clears control bits and restraps
      s_fib <= 1'b0;
      apb(1, 12'h000, 16'h4480);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      `CHK(sr_act, 1'b1)
      wait_for(sr_act, 1'b0);
      apb(0, 12'h000, 16'h0000);
      `CHK(rdata[15:0], 16'h3100)
      `CHK({isolate, mii_col}, 2'b00)
      $display("hard reset done");
      final_report();
   end

   // watchdog far beyond the expected run
   initial
   begin
      #(5000 * 100);
      err_total++;
      $display("BAD t=%0t watchdog expired", $time);
      final_report();
   end
endmodule : phy_basic_mode_control_bench
